// ==== alu_pkg.sv ====
// constants for the pc-relative, word add and byte concat-extract datapath slice
// assumes a 32-bit instruction word, 64-bit general registers and one core clock
// Operation
// [RL1] word-offset pc add: imm19<<2 plus aligned pc
// [RL2] pc-relative results sign-extend like virtual addresses
// [RL3] word-offset pc add: opcode, target, imm19 fields
// [RL4] word add modulo 2^32, sign-extended, never traps
// [RL5] software keeps word add operands sign-extended
// [RL6] word add: opcode, zero bit, function code
// [RL7] 32-bit concat-extract: shift, shift, or together
// [RL8] 32-bit concat-extract: byte position, zeros, function
// [RL9] 32-bit concat-extract result sign-extended on 64-bit
// [RL10] 64-bit concat-extract: shift, shift, or together
// [RL11] 64-bit concat-extract: opcode, byte position, function
// [RL12] 64-bit concat-extract traps unless 64-bit enabled
// [RL13] every byte position, zero included, is defined
// [RL14] upper pc add: imm16<<16, add, clear low 16
// [RL15] upper pc add: opcode, minor code, fields
// [RL16] unknown pc-relative minor code raises reserved trap
package alu_pkg;
  localparam int XLEN = 64;
  localparam int VA_BITS = 48; // implemented virtual address width
  localparam logic [5:0] OP_WORD_OP_GROUP_A = 6'h00;
  localparam logic [5:0] OP_DWORD_OP_GROUP = 6'h16;
  localparam logic [5:0] OP_PC_RELATIVE_GROUP = 6'h1e;
  localparam logic [9:0] FN_WORD_ADD_NONTRAP = 10'h150;
  localparam logic [5:0] FN_CONCAT_WORD = 6'h1f;
  localparam logic [5:0] FN_CONCAT_DWORD = 6'h1c;
  localparam logic [4:0] MINOR_UPPER_64K = 5'h1f;
  localparam logic [1:0] MINOR_WORD_OFFSET = 2'h0;
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 26;
  localparam int TGT_HI = 25;
  localparam int TGT_LO = 21;
  localparam int SRCA_HI = 20;
  localparam int SRCA_LO = 16;
  localparam int DST_HI = 15;
  localparam int DST_LO = 11;
  localparam int IMM19_W = 19;
  localparam int IMM16_W = 16;
  localparam int PC_ALIGN_BITS = 2;
  localparam int UPPER_SHIFT = 16;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_PC_WORD = 4'h1,
    OP_PC_UPPER = 4'h2,
    OP_WORD_ADD = 4'h3,
    OP_CAT_WORD = 4'h4,
    OP_CAT_DWORD = 4'h5,
    OP_RESERVED = 4'h6
  } alu_op_t;
endpackage

// ==== op_decoder.sv ====
`timescale 1ns/1ps
// decoder for the five operations of this datapath slice
// assumes the instruction word is stable while insn_valid is high
module op_decoder
  import alu_pkg::*;
(
  // instruction
  input wire logic [31:0] insn,
  input wire logic insn_valid,
  // decode result
  output alu_op_t op,
  output logic [4:0] dest
);
  logic [5:0] opc;
  assign opc = insn[OPC_HI:OPC_LO];

  // field match per operation; unmatched words outside the pc group go to op_none
  always_comb begin
    op = OP_NONE;
    dest = insn[TGT_HI:TGT_LO];
    if (insn_valid) begin
      if (opc == OP_PC_RELATIVE_GROUP) begin
        if (insn[20:19] == MINOR_WORD_OFFSET) begin
          op = OP_PC_WORD; // [RL3]
        end else if (insn[20:16] == MINOR_UPPER_64K) begin
          op = OP_PC_UPPER; // [RL15]
        end else begin
          op = OP_RESERVED; // [RL16]
        end
      end else if (opc == OP_WORD_OP_GROUP_A && insn[10] == 1'b0 && insn[9:0] == FN_WORD_ADD_NONTRAP) begin
        op = OP_WORD_ADD; // [RL6]
        dest = insn[DST_HI:DST_LO];
      end else if (opc == OP_WORD_OP_GROUP_A && insn[8:6] == 3'h0 && insn[5:0] == FN_CONCAT_WORD) begin
        op = OP_CAT_WORD; // [RL8]
        dest = insn[DST_HI:DST_LO];
      end else if (opc == OP_DWORD_OP_GROUP && insn[7:6] == 2'h0 && insn[5:0] == FN_CONCAT_DWORD) begin
        op = OP_CAT_DWORD; // [RL11]
        dest = insn[DST_HI:DST_LO];
      end
    end
  end
endmodule

// ==== byte_concat.sv ====
`timescale 1ns/1ps
// byte-granular concatenate-and-extract of two operands
// assumes pos is below W/8; pos of zero is a plain copy of src_b
module byte_concat #(
  parameter int W = 64,
  parameter int PW = 3
) (
  // operands
  input wire logic [W-1:0] src_b,
  input wire logic [W-1:0] src_a,
  input wire logic [PW-1:0] pos,
  // result
  output logic [W-1:0] result
);
  // right shift by a full width yields zero, so pos zero is defined [RL13]
  logic [PW+3:0] lsh;
  logic [PW+3:0] rsh;
  always_comb begin
    lsh = {1'b0, pos, 3'h0}; // widened on purpose so the full-width count W still fits
    rsh = (PW + 4)'(W) - lsh;
    result = (src_b << lsh) | (src_a >> rsh); // [RL7] [RL10]
  end
endmodule

// ==== pc_alu.sv ====
`timescale 1ns/1ps
// one-stage execute slice: pc-relative adds, non-trapping word add, concat-extract
// assumes the pipeline holds operands steady with insn_valid; result is one cycle later
module pc_alu
  import alu_pkg::*;
#(
  parameter bit IS_64 = 1'b1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // issue from decoder and register file
  input wire logic insn_valid,
  input wire logic [31:0] insn,
  input wire logic [63:0] pc,
  input wire logic [63:0] src_a_val,
  input wire logic [63:0] src_b_val,
  input wire logic ops64_enabled,
  // writeback
  output logic wb_valid,
  output logic [4:0] wb_dest,
  output logic [63:0] wb_data,
  output logic ri_exception
);
  alu_op_t op;
  logic [4:0] dest;
  logic [31:0] cat_w;
  logic [63:0] cat_d;
  logic [63:0] res;
  logic wr;
  logic trap;
  logic next_wb_valid;
  logic [4:0] next_wb_dest;
  logic [63:0] next_wb_data;
  logic next_ri_exception;

  op_decoder u_dec (
    .insn(insn),
    .insn_valid(insn_valid),
    .op(op),
    .dest(dest)
  );

  byte_concat #(.W(32), .PW(2)) u_cat_w (
    .src_b(src_b_val[31:0]),
    .src_a(src_a_val[31:0]),
    .pos(insn[10:9]),
    .result(cat_w)
  );

  byte_concat #(.W(64), .PW(3)) u_cat_d (
    .src_b(src_b_val),
    .src_a(src_a_val),
    .pos(insn[10:8]),
    .result(cat_d)
  );

  // virtual-address style sign extension of a pc-relative result
  function automatic logic [63:0] va_ext(input logic [63:0] v);
    logic [63:0] r;
    r = v;
    if (IS_64) begin
      r = {{(XLEN-VA_BITS){v[VA_BITS-1]}}, v[VA_BITS-1:0]}; // [RL2]
    end else begin
      r = {{32{v[31]}}, v[31:0]};
    end
    return r;
  endfunction

  // result select; operands outside word form give a defined but unspecified value
  always_comb begin
    logic [63:0] sum;
    logic [31:0] wsum;
    sum = '0;
    wsum = '0;
    res = '0;
    wr = 1'b0;
    trap = 1'b0;
    unique case (op)
      OP_PC_WORD: begin
        sum = (pc & ~64'h3) + {{(XLEN-IMM19_W-PC_ALIGN_BITS){insn[IMM19_W-1]}},
          insn[IMM19_W-1:0], {PC_ALIGN_BITS{1'b0}}}; // [RL1]
        res = va_ext(sum);
        wr = 1'b1;
      end
      OP_PC_UPPER: begin
        sum = pc + {{(XLEN-IMM16_W-UPPER_SHIFT){insn[IMM16_W-1]}}, insn[IMM16_W-1:0],
          {UPPER_SHIFT{1'b0}}};
        sum[UPPER_SHIFT-1:0] = '0; // [RL14]
        res = va_ext(sum);
        wr = 1'b1;
      end
      OP_WORD_ADD: begin
        wsum = src_a_val[31:0] + src_b_val[31:0]; // [RL4] wraps, no overflow trap
        res = {{32{wsum[31]}}, wsum};
        wr = 1'b1;
      end
      OP_CAT_WORD: begin
        res = IS_64 ? {{32{cat_w[31]}}, cat_w} : {32'h0, cat_w}; // [RL9]
        wr = 1'b1;
      end
      OP_CAT_DWORD: begin
        if (ops64_enabled) begin
          res = cat_d;
          wr = 1'b1;
        end else begin
          trap = 1'b1; // [RL12]
        end
      end
      OP_RESERVED: trap = 1'b1; // [RL16] no write
      OP_NONE: ;
      default: ;
    endcase
    next_wb_valid = wr;
    next_wb_dest = wr ? dest : 5'h0;
    next_wb_data = wr ? res : wb_data;
    next_ri_exception = trap;
  end

  // writeback registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wb_valid <= 1'b0;
      wb_dest <= 5'h0;
      wb_data <= 64'h0;
      ri_exception <= 1'b0;
    end else begin
      wb_valid <= next_wb_valid;
      wb_dest <= next_wb_dest;
      wb_data <= next_wb_data;
      ri_exception <= next_ri_exception;
    end
  end
endmodule

// ==== pc_alu_chk.sv ====
// checker on the pc_alu ports
// bound to every pc_alu, one clock domain
`timescale 1ns/1ps
module pc_alu_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // issue
  input wire logic insn_valid,
  input wire logic [31:0] insn,
  input wire logic [63:0] pc,
  input wire logic [63:0] src_a_val,
  input wire logic [63:0] src_b_val,
  input wire logic ops64_enabled,
  // writeback
  input wire logic wb_valid,
  input wire logic [4:0] wb_dest,
  input wire logic [63:0] wb_data,
  input wire logic ri_exception
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // own decode, so a decoder slip cannot hide itself
  wire [31:0] s = src_a_val[31:0] + src_b_val[31:0];
  wire g = insn_valid && insn[31:26] == 6'h1e;
  wire d = insn_valid && insn[31:26] == 6'h16 && insn[7:0] == 8'h1c;
  a_add_sext: assert property (insn_valid && insn[31:26] == 6'h0 && insn[10:0] == 11'h150 |=>
    wb_valid && wb_data == {{32{$past(s[31])}}, $past(s)}) else $error("word add wrong");
  a_word_pc: assert property (g && insn[20:19] == 2'h0 |=> wb_valid && wb_data[1:0] == 2'h0
    && wb_dest == $past(insn[25:21])) else $error("pc word add wrong");
  a_va_sext: assert property (g && insn[20:19] == 2'h0 |=> wb_data[63:47] == {17{wb_data[47]}})
    else $error("pc result not extended");
  a_upper_64k: assert property (g && insn[20:16] == 5'h1f |=> wb_valid && wb_data[15:0] == 16'h0)
    else $error("upper add not aligned");
  a_bad_minor: assert property (g && insn[20:19] == 2'h1 |=> ri_exception && !wb_valid)
    else $error("bad minor accepted");
  a_dword_trap: assert property (d && !ops64_enabled |=> ri_exception && wb_dest == 5'h0)
    else $error("dword op not trapped");
  a_dword_copy: assert property (d && ops64_enabled && insn[10:8] == 3'h0
    |=> wb_data == $past(src_b_val)) else $error("dword copy wrong");
  a_trap_alone: assert property (ri_exception |-> !wb_valid)
    else $error("trap with write");
endmodule
bind pc_alu pc_alu_chk pc_alu_chk_i (.*);

// ==== operand_src.sv ====
// operand source model on the register read side
// operands are valid only while an instruction is issued
`timescale 1ns/1ps
module operand_src (
  // control
  input wire logic insn_valid,
  input wire logic [63:0] a_in,
  input wire logic [63:0] b_in,
  // read ports
  output logic [63:0] src_a_val,
  output logic [63:0] src_b_val
);
  // idle ports carry the inverse so stale operands never pass for fresh
  assign src_a_val = insn_valid ? a_in : ~a_in;
  assign src_b_val = insn_valid ? b_in : ~b_in;
endmodule

// ==== tb_pc_alu.sv ====
// testbench for pc_alu fed by the operand source model
// 200 MHz clock, inputs change on falling edges
`timescale 1ns/1ps
module tb_pc_alu;
  logic core_clk = 1'b0, rst = 1'b1, insn_valid = 1'b0, ops64_enabled = 1'b1, wb_valid, ri_exception;
  logic [31:0] insn = 32'h0;
  logic [63:0] pc = 64'h0, a_in = 64'h0, b_in = 64'h0, a_val, b_val, wb_data;
  logic [4:0] wb_dest;
  int n_mismatch = 0;
  int compares = 0;
  operand_src operand_src_i (.insn_valid(insn_valid), .a_in(a_in), .b_in(b_in), .src_a_val(a_val), .src_b_val(b_val));
  pc_alu pc_alu_i (.core_clk(core_clk), .rst(rst), .insn_valid(insn_valid), .insn(insn), .pc(pc), .src_a_val(a_val),
    .src_b_val(b_val), .ops64_enabled(ops64_enabled), .wb_valid(wb_valid), .wb_dest(wb_dest), .wb_data(wb_data),
    .ri_exception(ri_exception));
  // clock and a watchdog on the whole run
  initial forever #2.5 core_clk = ~core_clk;
  initial begin
    #50000;
    n_mismatch++;
    stop_test();
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (n_mismatch == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic logic [63:0] sx(input logic [63:0] t);
    return {{16{t[47]}}, t[47:0]};
  endfunction
  // one instruction; its answer stands one edge later; st is {trap, write, dest}
  task automatic issue(input logic [31:0] i, input logic [63:0] a, b, exp, input logic [6:0] st);
    @(negedge core_clk);
    insn = i;
    a_in = a;
    b_in = b;
    insn_valid = 1'b1;
    @(negedge core_clk);
    insn_valid = 1'b0;
    chk({57'h0, ri_exception, wb_valid, wb_dest}, {57'h0, st});
    if (st[5]) chk(wb_data, exp);
  endtask
  // overflowing word-form sum wraps and extends, no trap
  task automatic t_add;
    issue({6'h0, 5'd2, 5'd3, 5'd4, 11'h150}, 64'h7fffffff, 64'h1, 64'hffffffff80000000, 7'h24);
  endtask
  // pc add crossing bit 47, then a negative upper add
  task automatic t_pc;
    logic [63:0] t;
    pc = 64'h7ffffffffffe;
    t = (pc & ~64'h3) + 64'h4;
    issue({6'h1e, 5'd7, 2'h0, 19'h1}, 0, 0, sx(t), 7'h27);
    t = pc + 64'hffffffff80000000;
    issue({6'h1e, 5'd8, 5'h1f, 16'h8000}, 0, 0, sx(t & ~64'hffff), 7'h28);
  endtask
  // every byte position of both widths, zero included
  task automatic t_cat;
    logic [63:0] a, b, e;
    logic [31:0] w;
    a = 64'h1122334455667788;
    b = 64'h99aabbccddeeff00;
    for (int p = 0; p < 8; p++) begin
      w = (b[31:0] << (8 * p)) | (a[31:0] >> (32 - 8 * p));
      e = {{32{w[31]}}, w};
      if (p < 4) issue({6'h0, 5'd2, 5'd3, 5'd5, p[1:0], 3'h0, 6'h1f}, a, b, e, 7'h25);
      e = (b << (8 * p)) | (a >> (64 - 8 * p));
      issue({6'h16, 5'd2, 5'd3, 5'd6, p[2:0], 2'h0, 6'h1c}, a, b, e, 7'h26);
    end
  endtask
  // refused encodings trap and write nothing
  task automatic t_trap;
    ops64_enabled = 1'b0;
    issue({6'h16, 5'd2, 5'd3, 5'd6, 11'h01c}, 0, 0, 0, 7'h40);
    ops64_enabled = 1'b1;
    for (int m = 1; m < 4; m++) begin
      issue({6'h1e, 5'd9, m[1:0], 19'h0}, 0, 0, 0, 7'h40);
    end
  endtask
  initial begin
    repeat (12) @(negedge core_clk);
    rst = 1'b0;
    t_add();
    t_pc();
    t_cat();
    t_trap();
    stop_test();
  end
endmodule
